// *** hw/dgc_defs.vh ***
// Purpose: constants for the dma/irq gating and floppy mode configuration block
// Assumes: apb byte addresses, 32-bit data, 8-bit registers in the low bits, gate register 15 bits
// Notes: definitions only
`ifndef DGC_DEFS_VH
`define DGC_DEFS_VH

// ****************************************
// register byte addresses
// ****************************************
`define DGC_OFF_DMA_SEL 12'h0074
`define DGC_OFF_FDD_MODE 12'h00f0
`define DGC_OFF_IRQ_LEVEL 12'h0070
`define DGC_OFF_GATES 12'h0100
`define DGC_OFF_STATUS 12'h0104

// ****************************************
// reset values
// ****************************************
`define DGC_RST_DMA_SEL 8'h04
`define DGC_RST_FDD_MODE 8'h0e
`define DGC_RST_IRQ_LEVEL 8'h00
`define DGC_RST_GATES 8'h00

// ****************************************
// field positions
// ****************************************
`define DGC_DMA_SEL_HI 2
`define DGC_DMA_SEL_LO 0
`define DGC_FM_ENH 0
`define DGC_FM_NONBURST 1
`define DGC_FM_IFM_HI 3
`define DGC_FM_IFM_LO 2
`define DGC_FM_RSV5 5
`define DGC_FM_PUSHPULL 6
`define DGC_FM_TRISTATE 7
`define DGC_IRQ_LVL_HI 3
`define DGC_IRQ_LVL_LO 0
// gate register: device enable bits plus parallel mode and dma/irq owner fields
`define DGC_G_FDC_DMA 0
`define DGC_G_FDC_PWR 1
`define DGC_G_SER1 2
`define DGC_G_SER2 3
`define DGC_G_PAR_IRQ 4
`define DGC_G_ECP_DMA 5
`define DGC_G_SER2_DMA 6
`define DGC_G_ACTIVE 7
`define DGC_G_PMODE_LO 8
`define DGC_G_PMODE_HI 10
`define DGC_G_ECP 11
`define DGC_G_OWNER_LO 12
`define DGC_G_OWNER_HI 13
`define DGC_G_BASE_OK 14
`define DGC_G_WIDTH 15

// ****************************************
// codes
// ****************************************
`define DGC_CH_NONE 3'h0
`define DGC_CH_LAST 3'h3
`define DGC_OWN_FDC 2'h0
`define DGC_OWN_PAR 2'h1
`define DGC_OWN_SER2 2'h2
`define DGC_IFM_RSV 2'h2
`define DGC_PM_FIFO 3'h2
`define DGC_PM_ECP 3'h3
`define DGC_PM_TEST 3'h6

`endif

// *** hw/dgc_pin_gate.v ***
// Purpose: one gated open pin, output plus active-low enable
// Assumes: enable low means the pin is driven
// Notes: used for each irq and dma request pin and for the floppy acknowledge pin
`timescale 1ns/10ps

module dgc_pin_gate (
    // clock and reset
    input wire CORE_CLK,
    input wire RST,
    // gating
    input wire use_pin,
    input wire level,
    // pin
    output reg PIN_O,
    output reg PIN_OE_N
);

// ****************************************
// registered drive
// ****************************************
// float while unused, so another device may own the line
always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
        PIN_O <= 1'b0;
        PIN_OE_N <= 1'b1;
    end else begin
        PIN_O <= use_pin & level;
        PIN_OE_N <= ~use_pin;
    end
end

endmodule

// *** hw/dgc_dma_irq_cfg.v ***
// Purpose: dma channel routing, irq/dack gating and floppy mode register
// Assumes: apb slave on CORE_CLK; RST is the hard reset (power-on or host reset)
// Notes: all pin outputs registered, one cycle behind their causes
// Notes: read data is taken in the setup cycle, so PREADY can stay high
// Behaviour
// RL1: channel select bits 2:0; 1..3 pick channel, 0 reserved, 4..7 none.
// RL2: dma active only for codes 1..3 with the device's own dma enable set.
// RL3: parallel port in extended mode also needs the ecr dma enable.
// RL4: second serial device also needs its own dma enable bit.
// RL5: dma request pins float when no device selects them.
// RL6: a block's own disable bit gates irq and dack, besides config disables.
// RL7: floppy dma gate clear floats floppy irq, dack and ignores requests.
// RL8: floppy powered down or disabled holds irq and dack floating.
// RL9: serial irq floats while its modem control gate bit is zero.
// RL10: standard/enhanced parallel modes float irq when its gate bit is zero.
// RL11: in extended mode the request pin follows the ecr dma gate, all modes.
// RL12: these registers reset only on hard reset, not on soft reset.
// RL13: mode bit 0 selects normal (0, default) or enhanced floppy mode.
// RL14: mode bit 1 selects burst (0) or non-burst (1, default) dma.
// RL15: mode bits 3:2 pick interface personality; 11 default, 10 reserved.
// RL16: software writes zero to mode bit 5; bit 4 reserved.
// RL17: mode bit 6 selects open drain (0) or push-pull (1) outputs.
// RL18: mode bit 7 tri-states all floppy interface outputs when one.
// RL19: bits 6 and 7 do not touch floppy signals on parallel port pins.
// RL20: irq asserted only with nonzero level select and device enable.
// RL21: irq pins float when no device selects them.
`timescale 1ns/10ps
`include "dgc_defs.vh"

module dgc_dma_irq_cfg #(
    parameter NUM_CH = 3
) (
    // clock and hard reset
    input wire CORE_CLK,
    input wire RST,
    // apb slave
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [11:0] PADDR,
    input wire [31:0] PWDATA,
    output wire PREADY,
    output reg [31:0] PRDATA,
    output wire PSLVERR,
    // logical device requests and interrupts
    input wire FDC_IRQ_IN,
    input wire FDC_DREQ_IN,
    input wire PAR_IRQ_IN,
    input wire PAR_DREQ_IN,
    input wire SER1_IRQ_IN,
    input wire SER2_IRQ_IN,
    input wire SER2_DREQ_IN,
    // host dma acknowledges, one per channel
    input wire [NUM_CH:1] DACK_IN,
    // device side of the acknowledge
    output reg FDC_DACK,
    output reg PAR_DACK,
    output reg SER2_DACK,
    // dma request pins
    output wire [NUM_CH:1] DREQ_O,
    output wire [NUM_CH:1] DREQ_OE_N,
    // irq pin of the selected level
    output wire IRQ_O,
    output wire IRQ_OE_N,
    // floppy acknowledge to the drive side
    output wire FDC_DACK_O,
    output wire FDC_DACK_OE_N,
    // floppy mode controls
    output reg FDC_ENHANCED,
    output reg FDC_NONBURST,
    output reg [1:0] FDC_IF_MODE,
    output reg FDC_PUSH_PULL,
    output reg FDC_OUT_TRISTATE,
    output reg PPFDC_PUSH_PULL,
    output reg PPFDC_OUT_TRISTATE
);

// ****************************************
// registers
// ****************************************
reg [7:0] dma_channel_select;
reg [7:0] floppy_mode_control;
reg [7:0] irq_level_select;
reg [`DGC_G_WIDTH-1:0] gates;

wire wr_en;
wire rd_en;
wire hit;
assign wr_en = PSEL & PENABLE & PWRITE;
// read data is picked in the setup cycle so it can leave a flop with no wait state
assign rd_en = PSEL & ~PENABLE & ~PWRITE;
assign PREADY = 1'b1; // zero-wait slave: the access phase always ends at once

// address decode
assign hit = (PADDR == `DGC_OFF_DMA_SEL) || (PADDR == `DGC_OFF_FDD_MODE) ||
             (PADDR == `DGC_OFF_IRQ_LEVEL) || (PADDR == `DGC_OFF_GATES) ||
             (PADDR == `DGC_OFF_STATUS);
assign PSLVERR = PSEL & PENABLE & ~hit;

// ****************************************
// gate field decode
// ****************************************
wire floppy_dma_gate;
wire floppy_powered;
wire serial_irq_gate1;
wire serial_irq_gate2;
wire parallel_irq_gate;
wire ecp_dma_gate;
wire ser2_dma_gate;
wire cfg_active;
wire [2:0] ecr_mode;
wire extended_capabilities_mode;
wire [1:0] dma_owner;
wire base_ok;
assign floppy_dma_gate = gates[`DGC_G_FDC_DMA];
assign floppy_powered = gates[`DGC_G_FDC_PWR];
assign serial_irq_gate1 = gates[`DGC_G_SER1];
assign serial_irq_gate2 = gates[`DGC_G_SER2];
assign parallel_irq_gate = gates[`DGC_G_PAR_IRQ];
assign ecp_dma_gate = gates[`DGC_G_ECP_DMA];
assign ser2_dma_gate = gates[`DGC_G_SER2_DMA];
assign cfg_active = gates[`DGC_G_ACTIVE];
assign ecr_mode = gates[`DGC_G_PMODE_HI:`DGC_G_PMODE_LO];
assign extended_capabilities_mode = gates[`DGC_G_ECP];
assign dma_owner = gates[`DGC_G_OWNER_HI:`DGC_G_OWNER_LO];
assign base_ok = gates[`DGC_G_BASE_OK];

// ****************************************
// register writes
// ****************************************
// RST is only the hard reset; soft resets never reach these flops
always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
        dma_channel_select <= `DGC_RST_DMA_SEL; // [RL12]
        floppy_mode_control <= `DGC_RST_FDD_MODE; // [RL12]
        irq_level_select <= `DGC_RST_IRQ_LEVEL;
        gates <= {`DGC_G_WIDTH{1'b0}};
    end else if (wr_en) begin
        if (PADDR == `DGC_OFF_DMA_SEL) begin
            dma_channel_select <= PWDATA[7:0];
        end else if (PADDR == `DGC_OFF_FDD_MODE) begin
            floppy_mode_control <= PWDATA[7:0];
        end else if (PADDR == `DGC_OFF_IRQ_LEVEL) begin
            irq_level_select <= PWDATA[7:0];
        end else if (PADDR == `DGC_OFF_GATES) begin
            gates <= PWDATA[`DGC_G_WIDTH-1:0];
        end
    end
end

// ****************************************
// dma channel decision
// ****************************************
wire [2:0] ch_code;
wire ch_valid;
reg own_dma_en;
wire dma_active;
assign ch_code = dma_channel_select[`DGC_DMA_SEL_HI:`DGC_DMA_SEL_LO]; // [RL1]
// 0 reserved and 4..7 mean no channel
assign ch_valid = (ch_code != `DGC_CH_NONE) && (ch_code <= `DGC_CH_LAST); // [RL1]

// owning device's own dma enable
always @* begin
    case (dma_owner)
        `DGC_OWN_FDC: own_dma_en = floppy_dma_gate & floppy_powered; // [RL2] [RL8]
        `DGC_OWN_PAR: own_dma_en = extended_capabilities_mode & ecp_dma_gate; // [RL3] [RL11]
        `DGC_OWN_SER2: own_dma_en = ser2_dma_gate; // [RL4]
        default: own_dma_en = 1'b0;
    endcase
end

assign dma_active = ch_valid & own_dma_en & cfg_active & base_ok; // [RL2] [RL6]

// selected source request; floppy requests ignored with its gate clear
reg src_dreq;
always @* begin
    case (dma_owner)
        `DGC_OWN_FDC: src_dreq = FDC_DREQ_IN & floppy_dma_gate; // [RL7]
        `DGC_OWN_PAR: src_dreq = PAR_DREQ_IN;
        `DGC_OWN_SER2: src_dreq = SER2_DREQ_IN;
        default: src_dreq = 1'b0;
    endcase
end

// ****************************************
// request pins, one gate per channel
// ****************************************
genvar gi;
generate
    for (gi = 1; gi <= NUM_CH; gi = gi + 1) begin : g_dreq
        dgc_pin_gate u_gate (
            .CORE_CLK(CORE_CLK),
            .RST(RST),
            .use_pin(dma_active && (ch_code == gi)), // [RL5]
            .level(src_dreq),
            .PIN_O(DREQ_O[gi]),
            .PIN_OE_N(DREQ_OE_N[gi])
        );
    end
endgenerate

// ****************************************
// acknowledge routing
// ****************************************
reg sel_dack;
wire fdc_dack_use;
integer ci;

// explicit pick keeps every index inside the acknowledge port range
always @* begin
    sel_dack = 1'b0;
    for (ci = 1; ci <= NUM_CH; ci = ci + 1) begin
        if (ch_valid && (ch_code == ci[2:0])) begin
            sel_dack = DACK_IN[ci];
        end
    end
end
// floppy dack floats unless gated, powered and configured
assign fdc_dack_use = dma_active && (dma_owner == `DGC_OWN_FDC); // [RL6] [RL7] [RL8]

always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
        FDC_DACK <= 1'b0;
        PAR_DACK <= 1'b0;
        SER2_DACK <= 1'b0;
    end else begin
        FDC_DACK <= fdc_dack_use & sel_dack;
        PAR_DACK <= dma_active && (dma_owner == `DGC_OWN_PAR) && sel_dack;
        SER2_DACK <= dma_active && (dma_owner == `DGC_OWN_SER2) && sel_dack;
    end
end

dgc_pin_gate u_fdc_dack (
    .CORE_CLK(CORE_CLK),
    .RST(RST),
    .use_pin(fdc_dack_use),
    .level(sel_dack),
    .PIN_O(FDC_DACK_O),
    .PIN_OE_N(FDC_DACK_OE_N)
);

// ****************************************
// interrupt gating
// ****************************************
// irq source follows the owner field; serial 1 uses owner code 3
reg irq_en;
reg irq_src;
wire par_irq_on;
// extended modes fifo, ecp and test drive the irq regardless of the gate bit
assign par_irq_on = extended_capabilities_mode &&
    ((ecr_mode == `DGC_PM_FIFO) || (ecr_mode == `DGC_PM_ECP) ||
     (ecr_mode == `DGC_PM_TEST));

always @* begin
    case (dma_owner)
        `DGC_OWN_FDC: begin
            irq_en = floppy_dma_gate & floppy_powered; // [RL7] [RL8]
            irq_src = FDC_IRQ_IN;
        end
        `DGC_OWN_PAR: begin
            irq_en = par_irq_on | parallel_irq_gate; // [RL10]
            irq_src = PAR_IRQ_IN;
        end
        `DGC_OWN_SER2: begin
            irq_en = serial_irq_gate2; // [RL9]
            irq_src = SER2_IRQ_IN;
        end
        default: begin
            irq_en = serial_irq_gate1; // [RL9]
            irq_src = SER1_IRQ_IN;
        end
    endcase
end

wire irq_use;
// nonzero level, device enable and config valid all needed
assign irq_use = (irq_level_select[`DGC_IRQ_LVL_HI:`DGC_IRQ_LVL_LO] != 4'h0) &&
                 irq_en && cfg_active && base_ok; // [RL20] [RL21] [RL6]

dgc_pin_gate u_irq (
    .CORE_CLK(CORE_CLK),
    .RST(RST),
    .use_pin(irq_use),
    .level(irq_src),
    .PIN_O(IRQ_O),
    .PIN_OE_N(IRQ_OE_N)
);

// ****************************************
// floppy mode outputs
// ****************************************
// parallel-port floppy pins keep fixed defaults: bits 6 and 7 do not reach them
always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
        FDC_ENHANCED <= 1'b0;
        FDC_NONBURST <= 1'b1;
        FDC_IF_MODE <= 2'h3;
        FDC_PUSH_PULL <= 1'b0;
        FDC_OUT_TRISTATE <= 1'b0;
        PPFDC_PUSH_PULL <= 1'b0;
        PPFDC_OUT_TRISTATE <= 1'b0;
    end else begin
        FDC_ENHANCED <= floppy_mode_control[`DGC_FM_ENH]; // [RL13]
        FDC_NONBURST <= floppy_mode_control[`DGC_FM_NONBURST]; // [RL14]
        FDC_IF_MODE <= floppy_mode_control[`DGC_FM_IFM_HI:`DGC_FM_IFM_LO]; // [RL15]
        FDC_PUSH_PULL <= floppy_mode_control[`DGC_FM_PUSHPULL]; // [RL17]
        FDC_OUT_TRISTATE <= floppy_mode_control[`DGC_FM_TRISTATE]; // [RL18]
        PPFDC_PUSH_PULL <= 1'b0; // [RL19]
        PPFDC_OUT_TRISTATE <= 1'b0; // [RL19]
    end
end

// ****************************************
// read mux
// ****************************************
// status word shows the live decisions so software sees why a pin floats
reg [31:0] next_prdata;
always @* begin
    next_prdata = 32'h0000_0000;
    if (rd_en) begin
        if (PADDR == `DGC_OFF_DMA_SEL) begin
            next_prdata = {24'h00_0000, dma_channel_select};
        end else if (PADDR == `DGC_OFF_FDD_MODE) begin
            next_prdata = {24'h00_0000, floppy_mode_control};
        end else if (PADDR == `DGC_OFF_IRQ_LEVEL) begin
            next_prdata = {24'h00_0000, irq_level_select};
        end else if (PADDR == `DGC_OFF_GATES) begin
            next_prdata = {17'h0_0000, gates};
        end else if (PADDR == `DGC_OFF_STATUS) begin
            next_prdata = {28'h000_0000, (floppy_mode_control[`DGC_FM_IFM_HI:`DGC_FM_IFM_LO]
                == `DGC_IFM_RSV), irq_use, dma_active, ch_valid};
        end
    end
end

// read data leaves a flop; it stands through the access phase, then returns to zero
// status is therefore one cycle old when seen, which software cannot tell apart
always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
        PRDATA <= 32'h0000_0000;
    end else begin
        PRDATA <= next_prdata;
    end
end

endmodule

// *** bench/dgc_cfg_props.sv ***
// Purpose: port checks for the dma/irq gating block
// Assumes: writes land at the access edge, pins follow one edge later
// Notes: shadows of written registers are kept here
`timescale 1ns/10ps

module dgc_cfg_props #(
    parameter NUM_CH = 3
) (
    // clock and reset
    input wire CORE_CLK,
    input wire RST,
    // apb
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [11:0] PADDR,
    input wire [31:0] PWDATA,
    input wire PREADY,
    input wire [31:0] PRDATA,
    input wire PSLVERR,
    // pins
    input wire [NUM_CH:1] DREQ_OE_N,
    input wire IRQ_OE_N,
    input wire FDC_DACK_OE_N,
    // mode outputs
    input wire FDC_ENHANCED,
    input wire FDC_NONBURST,
    input wire [1:0] FDC_IF_MODE,
    input wire FDC_PUSH_PULL,
    input wire FDC_OUT_TRISTATE,
    input wire PPFDC_PUSH_PULL,
    input wire PPFDC_OUT_TRISTATE
);
    wire acc = PSEL && PENABLE;
    wire wr = acc && PWRITE;
    wire mapped = PADDR == 12'h070 || PADDR == 12'h074 || PADDR == 12'h0f0 ||
        PADDR == 12'h100 || PADDR == 12'h104;
    reg [2:0] sel_q, sel_d;
    reg [3:0] lvl_q, lvl_d;
    reg [14:0] g_q, g_d;
    wire [3:1] use_d = {sel_d == 3'h3, sel_d == 3'h2, sel_d == 3'h1};
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (RST);

    // ****************************************
    // shadows, delayed once to line up with the pin registers
    // ****************************************
    always @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            sel_q <= 3'h4;
            lvl_q <= 4'h0;
            g_q <= 15'h0000;
            sel_d <= 3'h4;
            lvl_d <= 4'h0;
            g_d <= 15'h0000;
        end else begin
            if (wr && PADDR == 12'h074) sel_q <= PWDATA[2:0];
            if (wr && PADDR == 12'h070) lvl_q <= PWDATA[3:0];
            if (wr && PADDR == 12'h100) g_q <= PWDATA[14:0];
            sel_d <= sel_q;
            lvl_d <= lvl_q;
            g_d <= g_q;
        end
    end

    // ****************************************
    // properties
    // ****************************************
    property p_ready; acc |-> PREADY; endproperty
    a_ready: assert property (p_ready) else $error("no ready in access phase");
    property p_unmap; acc && !mapped |-> PSLVERR && PRDATA == 32'h0000_0000; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped access not refused");
    property p_mode;
        wr && PADDR == 12'h0f0 |-> ##2 {FDC_OUT_TRISTATE, FDC_PUSH_PULL, FDC_IF_MODE,
            FDC_NONBURST, FDC_ENHANCED} == {$past(PWDATA[7:6], 2), $past(PWDATA[3:0], 2)};
    endproperty
    a_mode: assert property (p_mode) else $error("mode outputs differ");
    property p_ppfdc; !PPFDC_PUSH_PULL && !PPFDC_OUT_TRISTATE; endproperty
    a_ppfdc: assert property (p_ppfdc) else $error("shared pins affected");
    property p_dsel; DREQ_OE_N != 3'h7 |-> (~DREQ_OE_N & ~use_d) == 3'h0; endproperty
    a_dsel: assert property (p_dsel) else $error("unselected request driven");
    property p_fdack; !FDC_DACK_OE_N |-> g_d[0] && g_d[1] && g_d[7]; endproperty
    a_fdack: assert property (p_fdack) else $error("floppy ack driven");
    property p_irq; !IRQ_OE_N |-> lvl_d != 4'h0 && g_d[7]; endproperty
    a_irq: assert property (p_irq) else $error("irq driven unselected");
    property p_ser1; !IRQ_OE_N && g_d[13:12] == 2'h3 |-> g_d[2]; endproperty
    a_ser1: assert property (p_ser1) else $error("serial irq ungated");
    property p_ecp; DREQ_OE_N != 3'h7 && g_d[13:12] == 2'h1 && g_d[11] |-> g_d[5]; endproperty
    a_ecp: assert property (p_ecp) else $error("ecp request ungated");
    property p_fdma; DREQ_OE_N != 3'h7 && g_d[13:12] == 2'h0 |-> g_d[0]; endproperty
    a_fdma: assert property (p_fdma) else $error("floppy request ungated");
    c_mode: cover property (wr && PADDR == 12'h0f0);
    c_irq: cover property (!IRQ_OE_N);
    c_dreq: cover property (DREQ_OE_N != 3'h7);
endmodule

// *** bench/dgc_host.sv ***
// Purpose: host dma controller answering request pins
// Assumes: request lines are pulled low while floating
// Notes: slow delays the acknowledge by one more cycle
`timescale 1ns/10ps

module dgc_host (
    // clock and reset
    input wire clk,
    input wire rst,
    // request pins and pace
    input wire [3:1] dreq,
    input wire [3:1] dreq_oe_n,
    input wire slow,
    // acknowledges
    output reg [3:1] dack
);
    reg [3:1] seen;
    reg [3:1] seen_d;
    // ack only while the request has stood long enough
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            seen <= 3'h0;
            seen_d <= 3'h0;
            dack <= 3'h0;
        end else begin
            seen <= dreq & ~dreq_oe_n;
            seen_d <= seen;
            dack <= slow ? (seen & seen_d) : seen;
        end
    end
endmodule

// *** bench/tb.sv ***
// Purpose: self-checking bench for the dma/irq gating block
// Assumes: request inputs high so driven pins read one
// Notes: pins are checked two edges after the last write
`timescale 1ns/10ps
`define CHK(n, e, v) check(n, e, v)

module tb;
    localparam [63:0] MV = 64'hcf80_4000_0408_0201;
    reg clk, rst, psel, penable, pwrite, slow, er;
    reg [11:0] paddr;
    reg [31:0] pwdata, rd;
    reg [6:0] req;
    integer err_count, n_checks, m;
    reg vc;
    wire pready, pslverr, irq_o, irq_oe_n, dk_oe_n, fdc_dack, enh, nb, pp, ts, pdk, sdk, dk_o;
    wire [1:0] ifm;
    wire [31:0] prdata;
    wire [3:1] dack, dreq_o, dreq_oe_n;

    dgc_dma_irq_cfg #(.NUM_CH(3)) i_dut (
        .CORE_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata),
        .PSLVERR(pslverr), .FDC_IRQ_IN(req[0]), .FDC_DREQ_IN(req[1]),
        .PAR_IRQ_IN(req[2]), .PAR_DREQ_IN(req[3]), .SER1_IRQ_IN(req[4]),
        .SER2_IRQ_IN(req[5]), .SER2_DREQ_IN(req[6]), .DACK_IN(dack),
        .FDC_DACK(fdc_dack), .PAR_DACK(pdk), .SER2_DACK(sdk), .DREQ_O(dreq_o),
        .DREQ_OE_N(dreq_oe_n), .IRQ_O(irq_o), .IRQ_OE_N(irq_oe_n), .FDC_DACK_O(dk_o),
        .FDC_DACK_OE_N(dk_oe_n), .FDC_ENHANCED(enh), .FDC_NONBURST(nb),
        .FDC_IF_MODE(ifm), .FDC_PUSH_PULL(pp), .FDC_OUT_TRISTATE(ts),
        .PPFDC_PUSH_PULL(), .PPFDC_OUT_TRISTATE());
    dgc_host i_host (.clk(clk), .rst(rst), .dreq(dreq_o), .dreq_oe_n(dreq_oe_n),
        .slow(slow), .dack(dack));

    // ****************************************
    // tasks
    // ****************************************
    task check(input string n, input logic [31:0] e, input logic [31:0] v);
        begin
            n_checks = n_checks + 1;
            if (v !== e) begin
                err_count = err_count + 1;
                $display("CHECK FAILED %s expected %h seen %h", n, e, v);
            end
        end
    endtask

    // one apb transfer; the edge before it lets the last release land
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        integer n;
        begin
            @(posedge clk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge clk);
            penable <= 1'b1;
            n = 0;
            @(posedge clk);
            while (pready !== 1'b1 && n < 50) begin
                n = n + 1;
                @(posedge clk);
            end
            if (n >= 50) err_count = err_count + 1;
            rd = prdata;
            er = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task reset_check;
        begin
            apb(1'b0, 12'h074, 32'h0000_0000);
            `CHK("dma select", 32'h0000_0004, rd);
            apb(1'b0, 12'h0f0, 32'h0000_0000);
            `CHK("floppy mode", 32'h0000_000e, rd);
            apb(1'b0, 12'h100, 32'h0000_0000);
            `CHK("gates", 32'h0000_0000, rd);
            apb(1'b0, 12'h080, 32'h0000_0000);
            `CHK("unmapped data", 32'h0000_0000, rd);
            `CHK("unmapped error", 32'h0000_0001, er);
            `CHK("idle pins", 32'h0000_00ff, {dreq_oe_n, irq_oe_n, dk_oe_n, nb, ifm});
            $display("test reset done");
        end
    endtask

    // program gates, channel and level, then compare the three floats
    task row(input logic [31:0] g, input logic [7:0] ch, input logic [3:0] lv,
            input logic ei, input logic [2:0] ed, input logic ek);
        begin
            apb(1'b1, 12'h100, g);
            apb(1'b1, 12'h074, {24'h00_0000, ch});
            apb(1'b1, 12'h070, {28'h000_0000, lv});
            repeat (2) @(posedge clk);
            `CHK("irq float", ei, irq_oe_n);
            `CHK("dreq float", ed, dreq_oe_n);
            `CHK("dack float", ek, dk_oe_n);
        end
    endtask

    task complete_run;
        begin
            $display("checks %0d mismatches %0d", n_checks, err_count);
            if (err_count == 0 && n_checks > 0) $display("TB: PASS");
            else $display("TB: FAIL");
            $finish;
        end
    endtask

    // ****************************************
    // clock, watchdog and tests
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial begin
        repeat (8000) @(posedge clk);
        err_count = err_count + 1;
        complete_run;
    end

    initial begin
        rst = 1'b1;
        {psel, penable, pwrite, slow, er} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        req = 7'h7f;
        err_count = 0;
        n_checks = 0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        reset_check;
        for (m = 0; m < 8; m = m + 1) begin
            apb(1'b1, 12'h0f0, {24'h00_0000, MV[m*8 +: 8]});
            repeat (2) @(posedge clk);
            `CHK("mode pins", MV[m*8 +: 8], {ts, pp, 2'h0, ifm, nb, enh});
            apb(1'b0, 12'h0f0, 32'h0000_0000);
            `CHK("mode read", MV[m*8 +: 8], rd);
            apb(1'b0, 12'h104, 32'h0000_0000);
            `CHK("status", {28'h000_0000, MV[m*8+2 +: 2] == 2'h2, 3'h0}, rd);
        end
        $display("test mode done");
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        reset_check;
        for (m = 0; m < 8; m = m + 1) begin
            vc = m >= 1 && m <= 3;
            row(32'h0000_4083, m[7:0], 4'h5, 1'b0, vc ? ~(3'h1 << (m - 1)) : 3'h7, !vc);
        end
        row(32'h0000_4082, 8'h02, 4'h5, 1'b1, 3'h7, 1'b1);
        row(32'h0000_4081, 8'h02, 4'h5, 1'b1, 3'h7, 1'b1);
        row(32'h0000_0083, 8'h02, 4'h5, 1'b1, 3'h7, 1'b1);
        row(32'h0000_4083, 8'h02, 4'h0, 1'b1, 3'h5, 1'b0);
        row(32'h0000_7080, 8'h02, 4'h5, 1'b1, 3'h7, 1'b1);
        row(32'h0000_7084, 8'h02, 4'h5, 1'b0, 3'h7, 1'b1);
        row(32'h0000_5080, 8'h02, 4'h5, 1'b1, 3'h7, 1'b1);
        row(32'h0000_5090, 8'h02, 4'h5, 1'b0, 3'h7, 1'b1);
        row(32'h0000_6088, 8'h02, 4'h5, 1'b0, 3'h7, 1'b1);
        row(32'h0000_60c8, 8'h02, 4'h5, 1'b0, 3'h5, 1'b1);
        for (m = 0; m < 8; m = m + 1) begin
            vc = !(m == 2 || m == 3 || m == 6);
            row(32'h0000_58a0 | (m << 8), 8'h02, 4'h5, vc, 3'h5, 1'b1);
            row(32'h0000_5880 | (m << 8), 8'h02, 4'h5, vc, 3'h7, 1'b1);
        end
        $display("test gating done");
        for (m = 0; m < 2; m = m + 1) begin
            slow <= m[0];
            row(32'h0000_4083, 8'h03, 4'h5, 1'b0, 3'h3, 1'b0);
            repeat (6) @(posedge clk);
            `CHK("request and ack", 32'h0000_003c, {dreq_o[3], fdc_dack, dk_o, irq_o, pdk, sdk});
            req <= 7'h7d;
            repeat (6) @(posedge clk);
            `CHK("request dropped", 32'h0000_0004, {dreq_o[3], fdc_dack, dk_o, irq_o, pdk, sdk});
            req <= 7'h7f;
        end
        $display("test host done");
        complete_run;
    end
endmodule

bind dgc_dma_irq_cfg dgc_cfg_props #(.NUM_CH(NUM_CH)) i_props (
    .CORE_CLK(CORE_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR),
    .DREQ_OE_N(DREQ_OE_N), .IRQ_OE_N(IRQ_OE_N), .FDC_DACK_OE_N(FDC_DACK_OE_N),
    .FDC_ENHANCED(FDC_ENHANCED), .FDC_NONBURST(FDC_NONBURST), .FDC_IF_MODE(FDC_IF_MODE),
    .FDC_PUSH_PULL(FDC_PUSH_PULL), .FDC_OUT_TRISTATE(FDC_OUT_TRISTATE),
    .PPFDC_PUSH_PULL(PPFDC_PUSH_PULL), .PPFDC_OUT_TRISTATE(PPFDC_OUT_TRISTATE));
